// ==== common/ltcl_pkg.sv ====
// Shared constants and carriers for the limit table command loader.
// Assumes one 40 MHz clock and a text stream of one character per cycle.
package ltcl_pkg;

	// Characters of the command text
	localparam logic [7:0] CH_HASH  = 8'h23;
	localparam logic [7:0] CH_STAR  = 8'h2A;
	localparam logic [7:0] CH_COMMA = 8'h2C;
	localparam logic [7:0] CH_SEMI  = 8'h3B;
	localparam logic [7:0] CH_SPACE = 8'h20;
	localparam logic [7:0] CH_MINUS = 8'h2D;
	localparam logic [7:0] CH_PLUS  = 8'h2B;
	localparam logic [7:0] CH_DOT   = 8'h2E;
	localparam logic [7:0] CH_ZERO  = 8'h30;
	localparam logic [7:0] CH_NINE  = 8'h39;
	localparam logic [7:0] CH_E_UP  = 8'h45;
	localparam logic [7:0] CH_E_LO  = 8'h65;

	// Four-letter opcodes, first letter in the top byte
	localparam logic [31:0] OPC_DOUBLE = 32'h534C_4457;
	localparam logic [31:0] OPC_SINGLE = 32'h534C_4957;
	localparam logic [31:0] OPC_NAME   = 32'h534C_4945;
	localparam logic [31:0] OPC_MARGIN = 32'h534C_494D;

	// Table geometry and field counts
	localparam int unsigned NPTS     = 16;
	localparam int unsigned IDX_W    = 4;
	localparam int unsigned NAME_MAX = 10;
	localparam int unsigned NLEN_W   = 4;
	localparam logic [2:0]  NF_DBL   = 3'h4;
	localparam logic [2:0]  NF_SGL   = 3'h3;
	localparam logic [2:0]  NF_MRG   = 3'h1;
	localparam logic [2:0]  NF_MAX   = 3'h4;
	localparam logic [3:0]  EXP_MAX  = 4'h9;

	// Margin bounds in dB
	localparam logic signed [31:0] MARGIN_MIN = -32'sd20;
	localparam logic signed [31:0] MARGIN_MAX = 32'sd20;

	typedef enum logic [2:0] {
		LTCL_CMD_NONE,
		LTCL_CMD_DOUBLE,
		LTCL_CMD_SINGLE,
		LTCL_CMD_NAME,
		LTCL_CMD_MARGIN
	} ltcl_cmd_e;

	typedef struct packed {
		logic        valid;
		logic [7:0]  data;
	} ltcl_char_s;

	typedef struct packed {
		logic [31:0]        freq;
		logic signed [15:0] lev_q;
		logic signed [15:0] lev_a;
	} ltcl_point_s;

	typedef struct packed {
		ltcl_cmd_e cmd;
		logic      ok;
	} ltcl_reply_s;

endpackage

// ==== hdl/ltcl_num_field.sv ====
// Decimal field parser: sign, digits, optional fraction and exponent.
// Assumes the caller clears it before a field and waits for done.
module ltcl_num_field
	import ltcl_pkg::*;
(
	input  wire logic               clock_i,  // System clock
	input  wire logic               rst_n_i,  // Sync reset, low
	input  wire logic               clear_i,  // Start a new field
	input  wire logic               push_i,   // Character strobe
	input  wire logic [7:0]         char_i,   // Character
	input  wire logic               finish_i, // Field ended
	output logic signed [31:0]      value_o,  // Parsed value
	output logic                    has_o,    // Digits seen
	output logic                    bad_o,    // Malformed field
	output logic                    done_o    // Value ready, pulse
);
	logic [31:0] mant;
	logic        neg;
	logic        in_exp;
	logic        in_frac;
	logic [3:0]  expn;
	logic        scaling;
	logic [7:0]  digit;

	assign digit = char_i - CH_ZERO;
	assign value_o = neg ? -$signed(mant) : $signed(mant);

	always_ff @(posedge clock_i)
	begin
		done_o <= 1'b0;
		if (!rst_n_i || clear_i)
		begin
			mant    <= '0;
			neg     <= 1'b0;
			in_exp  <= 1'b0;
			in_frac <= 1'b0;
			expn    <= '0;
			scaling <= 1'b0;
			has_o   <= 1'b0;
			bad_o   <= 1'b0;
		end
		else if (scaling)
		begin
			// Exponent applied one decade per cycle
			if (expn == 4'h0)
			begin
				scaling <= 1'b0;
				done_o  <= 1'b1;
			end
			else
			begin
				mant <= (mant << 3) + (mant << 1);
				expn <= expn - 4'h1;
			end
		end
		else if (finish_i)
			scaling <= 1'b1;
		else if (push_i)
		begin
			if (char_i >= CH_ZERO && char_i <= CH_NINE)
			begin
				if (in_exp)
				begin
					if (expn > EXP_MAX)
						bad_o <= 1'b1;
					expn <= 4'((expn << 3) + (expn << 1) + digit[3:0]);
				end
				else if (!in_frac)
				begin
					mant  <= (mant << 3) + (mant << 1) + {24'h00_0000, digit};
					has_o <= 1'b1;
				end
			end
			else if (char_i == CH_MINUS && !has_o && !in_exp)
				neg <= 1'b1;
			else if (char_i == CH_DOT && !in_exp)
				in_frac <= 1'b1;
			else if ((char_i == CH_E_UP || char_i == CH_E_LO) && has_o)
				in_exp <= 1'b1;
			else if (char_i != CH_PLUS)
				bad_o <= 1'b1;
		end
	end

endmodule

// ==== hdl/ltcl_top.sv ====
// Limit table command loader: parses framed text commands, keeps the
// point table, limit name, activation and smart detector margin.
// Assumes characters arrive one per cycle, held while rx_ready_o is low.
//
// What this block does
// - Double point write carries index 0..15, frequency, two levels.
// - Single point write carries index 0..15, frequency, one level.
// - Frequency accepted plain or exponential, taken as hertz.
// - Storing a point clears every point with a higher index.
// - Point write answered OK when granted, rejected otherwise.
// - Named activate checks coherence, then stores name, activates, OK.
// - Activate with no name deactivates any active limit.
// - Double-level limit is offered to the smart detector on sweeps.
// - Margin -20..20 dB sets threshold to limit minus margin, else rejected.
module ltcl_top
	import ltcl_pkg::*;
(
	input  wire logic                     clock_i,        // 40 MHz clock
	input  wire logic                     rst_n_i,        // Sync reset, low
	input  wire ltcl_pkg::ltcl_char_s     rx_i,           // Text character
	output logic                          rx_ready_o,     // Char accepted
	output logic                          reply_valid_o,  // Reply pulse
	output ltcl_pkg::ltcl_reply_s         reply_o,        // Reply content
	input  wire logic [3:0]               rd_index_i,     // Table read index
	output ltcl_pkg::ltcl_point_s         rd_point_o,     // Table point
	output logic                          rd_valid_o,     // Point present
	output logic signed [15:0]            rd_threshold_o, // Detector level
	output logic                          limit_active_o, // Limit in use
	output logic                          smart_enable_o, // Sweep detector
	output logic signed [7:0]             margin_o,       // Margin in dB
	output logic [8*NAME_MAX-1:0]         name_o,         // Limit name
	output logic [NLEN_W-1:0]             name_len_o      // Name length
);
	import ltcl_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Parser state

	typedef enum logic [2:0] {
		S_IDLE, S_OPC, S_FIELD, S_WAIT, S_NAME, S_EXEC
	} ltcl_state_e;

	ltcl_state_e        state;
	ltcl_cmd_e          cmd;
	logic [31:0]        opc;
	logic [1:0]         opc_cnt;
	logic signed [31:0] fld [NF_MAX];
	logic [2:0]         fcnt;
	logic               fbad;
	logic               end_seen;
	logic [7:0]         nbuf [NAME_MAX];
	logic [NLEN_W-1:0]  npos;
	logic [NLEN_W-1:0]  nlen;
	ltcl_point_s        pts [NPTS];
	logic [NPTS-1:0]    pvalid;
	logic [NPTS-1:0]    pdouble;

	logic               take;
	logic [7:0]         ch;
	logic               is_delim;
	logic               num_clr;
	logic               num_push;
	logic               num_fin;
	logic signed [31:0] num_val;
	logic               num_has;
	logic               num_bad;
	logic               num_done;
	logic [IDX_W-1:0]   widx;
	logic               idx_ok;
	logic               wr_ok;
	logic               mrg_ok;
	logic               coherent;
	logic               tbl_double;
	logic [31:0]        next_opc;

	assign take     = rx_i.valid && rx_ready_o;
	assign ch       = rx_i.data;
	assign is_delim = ch == CH_COMMA || ch == CH_SEMI || ch == CH_STAR;
	assign next_opc = {opc[23:0], ch};
	assign num_push = take && state == S_FIELD && !is_delim
		&& ch != CH_SPACE && ch != CH_HASH;
	assign num_fin  = take && state == S_FIELD && is_delim && num_has;
	assign num_clr  = (take && ch == CH_HASH) || num_done;
	assign widx     = fld[0][IDX_W-1:0];
	assign idx_ok   = fld[0] >= 0 && fld[0] < 32'(NPTS);
	assign wr_ok    = !fbad && idx_ok
		&& ((cmd == LTCL_CMD_DOUBLE && fcnt == NF_DBL)
		|| (cmd == LTCL_CMD_SINGLE && fcnt == NF_SGL));
	assign mrg_ok   = !fbad && fcnt == NF_MRG
		&& fld[0] >= MARGIN_MIN && fld[0] <= MARGIN_MAX;

	ltcl_num_field ltcl_num_field_inst (
		.clock_i  (clock_i),
		.rst_n_i  (rst_n_i),
		.clear_i  (num_clr),
		.push_i   (num_push),
		.char_i   (ch),
		.finish_i (num_fin),
		.value_o  (num_val),
		.has_o    (num_has),
		.bad_o    (num_bad),
		.done_o   (num_done)
	);

	////////////////////////////////////////////////////////////////////
	// Framing and field collection

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			state      <= S_IDLE;
			rx_ready_o <= 1'b1;
			opc        <= '0;
			opc_cnt    <= '0;
			cmd        <= LTCL_CMD_NONE;
			fcnt       <= '0;
			fbad       <= 1'b0;
			end_seen   <= 1'b0;
			npos       <= '0;
			nlen       <= '0;
		end
		else if (take && ch == CH_HASH && state != S_WAIT)
		begin
			state   <= S_OPC;
			opc_cnt <= '0;
			fcnt    <= '0;
			fbad    <= 1'b0;
			npos    <= '0;
			nlen    <= '0;
		end
		else
		begin
			unique case (state)
				S_IDLE: ;
				S_OPC:
					if (take && ch == CH_STAR)
						state <= S_IDLE;
					else if (take && ch != CH_SPACE)
					begin
						opc     <= next_opc;
						opc_cnt <= opc_cnt + 2'h1;
						if (opc_cnt == 2'h3)
						begin
							unique case (next_opc)
								OPC_DOUBLE: cmd <= LTCL_CMD_DOUBLE;
								OPC_SINGLE: cmd <= LTCL_CMD_SINGLE;
								OPC_NAME:   cmd <= LTCL_CMD_NAME;
								OPC_MARGIN: cmd <= LTCL_CMD_MARGIN;
								default:    cmd <= LTCL_CMD_NONE;
							endcase
							unique case (next_opc)
								OPC_DOUBLE, OPC_SINGLE, OPC_MARGIN:
									state <= S_FIELD;
								OPC_NAME: state <= S_NAME;
								default:  state <= S_IDLE;
							endcase
						end
					end
				S_FIELD:
					if (num_fin)
					begin
						rx_ready_o <= 1'b0;
						end_seen   <= ch == CH_STAR;
						state      <= S_WAIT;
					end
					else if (take && ch == CH_STAR)
						state <= S_EXEC;
					else if (take && is_delim)
						fbad <= 1'b1;
				S_WAIT:
					if (num_done)
					begin
						rx_ready_o <= 1'b1;
						fbad <= fbad || num_bad || fcnt == NF_MAX;
						if (fcnt != NF_MAX)
							fcnt <= fcnt + 3'h1;
						state <= end_seen ? S_EXEC : S_FIELD;
					end
				S_NAME:
					if (take && ch == CH_STAR)
						state <= S_EXEC;
					else if (take && !(npos == '0 && ch == CH_SPACE))
					begin
						if (npos != NLEN_W'(NAME_MAX))
						begin
							npos <= npos + 1'b1;
							if (ch != CH_SPACE)
								nlen <= npos + 1'b1;
						end
					end
				S_EXEC:
					state <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (num_done && fcnt != NF_MAX)
			fld[fcnt[1:0]] <= num_val;
		if (take && state == S_NAME && npos != NLEN_W'(NAME_MAX))
			nbuf[npos] <= ch;
	end

	////////////////////////////////////////////////////////////////////
	// Table coherence: contiguous from index 0, frequencies never falling,
	// one level kind throughout

	always_comb
	begin
		coherent   = pvalid[0];
		tbl_double = pdouble[0];
		for (int i = 1; i < NPTS; i++)
		begin
			if (pvalid[i])
			begin
				if (!pvalid[i-1] || pts[i].freq < pts[i-1].freq
					|| pdouble[i] != pdouble[0])
					coherent = 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Command execution

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			pvalid  <= '0;
			pdouble <= '0;
		end
		else if (state == S_EXEC && wr_ok)
		begin
			for (int i = 0; i < NPTS; i++)
			begin
				if (i > widx)
					pvalid[i] <= 1'b0;
			end
			pvalid[widx]     <= 1'b1;
			pdouble[widx]    <= cmd == LTCL_CMD_DOUBLE;
			pts[widx].freq   <= fld[1];
			pts[widx].lev_q  <= fld[2][15:0];
			pts[widx].lev_a  <= cmd == LTCL_CMD_DOUBLE ?
				fld[3][15:0] : fld[2][15:0];
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			limit_active_o <= 1'b0;
			margin_o       <= '0;
			name_o         <= '0;
			name_len_o     <= '0;
		end
		else if (state == S_EXEC && cmd == LTCL_CMD_NAME)
		begin
			if (nlen == '0)
				limit_active_o <= 1'b0;
			else if (coherent)
			begin
				limit_active_o <= 1'b1;
				name_len_o     <= nlen;
				for (int i = 0; i < NAME_MAX; i++)
					name_o[8*i +: 8] <= i < nlen ? nbuf[i] : 8'h00;
			end
		end
		else if (state == S_EXEC && cmd == LTCL_CMD_MARGIN && mrg_ok)
			margin_o <= fld[0][7:0];
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			reply_valid_o <= 1'b0;
			reply_o       <= '{cmd: LTCL_CMD_NONE, ok: 1'b0};
		end
		else
		begin
			reply_valid_o <= state == S_EXEC && cmd != LTCL_CMD_NONE;
			if (state == S_EXEC)
			begin
				reply_o.cmd <= cmd;
				unique case (cmd)
					LTCL_CMD_DOUBLE, LTCL_CMD_SINGLE:
						reply_o.ok <= wr_ok;
					LTCL_CMD_NAME:
						reply_o.ok <= nlen == '0 || coherent;
					LTCL_CMD_MARGIN:
						reply_o.ok <= mrg_ok;
					LTCL_CMD_NONE:
						reply_o.ok <= 1'b0;
				endcase
			end
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			smart_enable_o <= 1'b0;
			rd_valid_o     <= 1'b0;
			rd_point_o     <= '0;
			rd_threshold_o <= '0;
		end
		else
		begin
			smart_enable_o <= limit_active_o && tbl_double;
			rd_valid_o     <= pvalid[rd_index_i];
			rd_point_o     <= pts[rd_index_i];
			rd_threshold_o <= pts[rd_index_i].lev_a
				- 16'(margin_o);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	sequence field_end_s;
		state == S_FIELD && num_fin;
	endsequence
	sequence exec_write_s;
		state == S_EXEC && wr_ok;
	endsequence

	frame_idle_a: assert property (state == S_IDLE && take
		&& ch != CH_HASH |=> state == S_IDLE)
		else $error("text outside a frame left idle");
	exp_bound_a: assert property (field_end_s
		|=> !rx_ready_o [*1] ##[1:16] num_done)
		else $error("field value not ready in time");
	higher_clear_a: assert property (exec_write_s
		|=> (pvalid >> ($past(widx) + 5'h1)) == '0)
		else $error("higher points not cleared");
	reply_time_a: assert property (state == S_EXEC
		&& cmd != LTCL_CMD_NONE |=> reply_valid_o && reply_o.cmd == $past(cmd))
		else $error("reply missing after command");
	dbl_fields_a: assert property (state == S_EXEC
		&& cmd == LTCL_CMD_DOUBLE && fcnt != NF_DBL |=> !reply_o.ok)
		else $error("double write with wrong field count granted");
	sgl_fields_a: assert property (state == S_EXEC
		&& cmd == LTCL_CMD_SINGLE && fcnt != NF_SGL |=> !reply_o.ok)
		else $error("single write with wrong field count granted");
	activate_coh_a: assert property ($rose(limit_active_o)
		|-> $past(coherent) && reply_valid_o && reply_o.ok)
		else $error("limit activated without coherent table");
	deactivate_a: assert property (state == S_EXEC
		&& cmd == LTCL_CMD_NAME && nlen == '0 |=> !limit_active_o)
		else $error("empty name did not deactivate");
	smart_gate_a: assert property (smart_enable_o
		|-> $past(limit_active_o) && $past(tbl_double))
		else $error("smart detector enabled without double limit");
	margin_rng_a: assert property (state == S_EXEC
		&& cmd == LTCL_CMD_MARGIN && fld[0] > MARGIN_MAX
		|=> reply_valid_o && !reply_o.ok && $stable(margin_o))
		else $error("out of range margin accepted");

endmodule

// ==== tb/ltcl_host.sv ====
// Host model: offers framed command text one character per cycle.
// Assumes each send starts just after a rising clock edge.
module ltcl_host
	import ltcl_pkg::*;
(
	input  wire logic            clock_i,    // System clock
	input  wire logic            rx_ready_i, // Character taken
	output ltcl_pkg::ltcl_char_s rx_o        // Character offered
);
	timeunit 1ns;
	timeprecision 1ps;

	int overruns = 0;

	initial rx_o = '0;

	////////////////////////////////////////////////////////////////////////
	// Holds each character until taken or 20 further cycles pass; idle data is the inverse
	task automatic send(input string s);
		int w;
		for (int i = 0; i < s.len(); i++)
		begin
			rx_o <= '{valid: 1'b1, data: s[i]};
			w = 0;
			@(posedge clock_i);
			while (!rx_ready_i && w < 20)
			begin
				w++;
				@(posedge clock_i);
			end
			if (w == 20)
				overruns++;
		end
		rx_o <= '{valid: 1'b0, data: ~s[s.len()-1]};
	endtask
endmodule

// ==== tb/ltcl_top_test.sv ====
// Self-checking bench for the limit table command loader.
// Assumes the host model ltcl_host and the package constants.
module ltcl_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import ltcl_pkg::*;

	logic               clock_i = 1'b0;
	logic               rst_n_i = 1'b0;
	logic [3:0]         rd_index_i = 4'h0;
	ltcl_char_s         rx_i;
	logic               rx_ready_o;
	logic               reply_valid_o;
	ltcl_reply_s        reply_o;
	ltcl_point_s        rd_point_o;
	logic               rd_valid_o;
	logic signed [15:0] rd_threshold_o;
	logic               limit_active_o;
	logic               smart_enable_o;
	logic signed [7:0]  margin_o;
	logic [79:0]        name_o;
	logic [3:0]         name_len_o;
	int                 fails = 0;
	int                 n_tests = 0;

	always #12.5 clock_i = ~clock_i;

	ltcl_top ltcl_top_inst (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .rx_i(rx_i),
		.rx_ready_o(rx_ready_o), .reply_valid_o(reply_valid_o),
		.reply_o(reply_o), .rd_index_i(rd_index_i),
		.rd_point_o(rd_point_o), .rd_valid_o(rd_valid_o),
		.rd_threshold_o(rd_threshold_o), .limit_active_o(limit_active_o),
		.smart_enable_o(smart_enable_o), .margin_o(margin_o),
		.name_o(name_o), .name_len_o(name_len_o)
	);

	ltcl_host ltcl_host_inst (
		.clock_i(clock_i), .rx_ready_i(rx_ready_o), .rx_o(rx_i)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		fails += ltcl_host_inst.overruns;
		$display("Checks %0d, errors %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	function automatic string f(input logic [31:0] opc, input string a);
		return $sformatf("#%s%s*", opc, a);
	endfunction

	// Sends a frame, waits for its reply, then one edge for lagging flags
	task automatic run(input string s, input ltcl_cmd_e c, input logic ok);
		int w;
		w = 0;
		ltcl_host_inst.send(s);
		while (reply_valid_o !== 1'b1 && w < 40)
		begin
			w++;
			@(posedge clock_i);
		end
		if (w == 40)
		begin
			fails++;
			summarize();
		end
		check({reply_o.cmd, reply_o.ok}, {c, ok});
		@(posedge clock_i);
	endtask

	task automatic pt(input logic [3:0] i);
		rd_index_i <= i;
		repeat (3) @(posedge clock_i);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic s_frame();
		run({"x5*", f(OPC_SINGLE, "0,7E+1;9")}, LTCL_CMD_SINGLE, 1'b1);
		pt(4'h0);
		check(rd_point_o, {32'h0000_0046, 16'h0009, 16'h0009});
	endtask

	task automatic s_single();
		run(f(OPC_SINGLE, " 0, 150e3; 66"), LTCL_CMD_SINGLE, 1'b1);
		run(f(OPC_SINGLE, "1,500000;56"), LTCL_CMD_SINGLE, 1'b1);
		pt(4'h0);
		check(rd_point_o, {32'h0002_49F0, 16'h0042, 16'h0042});
		pt(4'h1);
		check({rd_valid_o, rd_point_o.freq}, {1'b1, 32'h0007_A120});
		run(f(OPC_NAME, " Lim"), LTCL_CMD_NAME, 1'b1);
		check({limit_active_o, smart_enable_o}, 2'b10);
	endtask

	task automatic s_reject();
		run(f(OPC_DOUBLE, "16,1e3;1,1"), LTCL_CMD_DOUBLE, 1'b0);
		run(f(OPC_DOUBLE, "0,1e3;1"), LTCL_CMD_DOUBLE, 1'b0);
		run(f(OPC_SINGLE, "0,1e3;1,1"), LTCL_CMD_SINGLE, 1'b0);
		run(f(OPC_SINGLE, "0,,1"), LTCL_CMD_SINGLE, 1'b0);
		run(f(OPC_SINGLE, "0,1e-3;1"), LTCL_CMD_SINGLE, 1'b0);
		pt(4'h1);
		check(rd_valid_o, 1'b1);
	endtask

	task automatic s_clear();
		for (int i = 0; i < 4; i++)
			run(f(OPC_DOUBLE, $sformatf("%0d,%0d00;60,50", i, i + 1)),
				LTCL_CMD_DOUBLE, 1'b1);
		run(f(OPC_DOUBLE, "15,900;60,50"), LTCL_CMD_DOUBLE, 1'b1);
		pt(4'hF);
		check(rd_valid_o, 1'b1);
		run(f(OPC_DOUBLE, "1,200;60,50"), LTCL_CMD_DOUBLE, 1'b1);
		pt(4'h2);
		check(rd_valid_o, 1'b0);
		pt(4'hF);
		check(rd_valid_o, 1'b0);
		pt(4'h1);
		check(rd_point_o, {32'h0000_00C8, 16'h003C, 16'h0032});
	endtask

	task automatic s_active();
		run(f(OPC_NAME, " Custom Double"), LTCL_CMD_NAME, 1'b1);
		check({limit_active_o, smart_enable_o}, 2'b11);
		check({name_len_o, name_o[7:0], name_o[79:72]}, 20'hA_4375);
		run(f(OPC_DOUBLE, "1,50;60,50"), LTCL_CMD_DOUBLE, 1'b1);
		run(f(OPC_NAME, " Bad"), LTCL_CMD_NAME, 1'b0);
		check({limit_active_o, name_len_o}, 5'h1A);
		run(f(OPC_NAME, " "), LTCL_CMD_NAME, 1'b1);
		check({limit_active_o, smart_enable_o}, 2'b00);
	endtask

	task automatic s_margin();
		run(f(OPC_MARGIN, " 2.7"), LTCL_CMD_MARGIN, 1'b1);
		pt(4'h0);
		check({margin_o, rd_threshold_o}, 24'h02_0030);
		run(f(OPC_MARGIN, "-20"), LTCL_CMD_MARGIN, 1'b1);
		pt(4'h0);
		check({margin_o, rd_threshold_o}, 24'hEC_0046);
		run(f(OPC_MARGIN, "20"), LTCL_CMD_MARGIN, 1'b1);
		run(f(OPC_MARGIN, "21"), LTCL_CMD_MARGIN, 1'b0);
		run(f(OPC_MARGIN, "-21"), LTCL_CMD_MARGIN, 1'b0);
		pt(4'h0);
		check({margin_o, rd_threshold_o}, 24'h14_001E);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (5) @(posedge clock_i);
		rst_n_i <= 1'b1;
		@(posedge clock_i);
		check({rx_ready_o, limit_active_o, margin_o}, 10'h200);
		s_frame();
		s_single();
		s_reject();
		s_clear();
		s_active();
		s_margin();
		summarize();
	end
endmodule
